/* logic/cmx_exec.sv */
// Execute unit for pointer loads, moves, multiplies, no-op and complement
// Function
// - Opcode 0x70 with a literal loads the pointer high byte in one cycle, flags untouched.
// - Opcode 0x71 with a literal loads the pointer low byte in one cycle, flags untouched.
// - A skipped pointer byte load also skips the following instruction.
// - Move to memory writes the accumulator to the addressed byte, nothing else changes.
// - Move to accumulator copies the addressed byte and sets zero from the value.
// - Move literal loads the accumulator in one cycle, flags untouched.
// - Signed multiply by memory puts low byte in accumulator, high byte in product high.
// - Signed multiply by literal puts low byte in accumulator, high byte in product high.
// - Signed products treat both bytes as two's complement, 16-bit result, no flags.
// - Unsigned multiply by memory gives a 16-bit product split as above, memory kept.
// - Unsigned multiply by literal gives a 16-bit product split as above, no flags.
// - The zero opcode changes nothing and takes exactly one cycle.
// - Complement in place inverts the addressed byte, writes it back, sets zero from it.
`timescale 1ns/1ps
`default_nettype none
`include "cmx_params.svh"
module cmx_exec (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic instr_valid,
   input wire logic [15:0] instr_word,
   input wire logic instr_skip,
   input wire logic [7:0] mem_rdata,
   output logic [8:0] mem_addr,
   output logic mem_we,
   output logic [7:0] mem_wdata,
   output logic [7:0] acc,
   output logic [7:0] pointer_high_byte,
   output logic [7:0] pointer_low_byte,
   output logic [7:0] product_high_byte,
   output logic zero_flag,
   output logic skip_next,
   output logic retired
);
   typedef struct packed {
      logic [7:0] acc;
      logic [7:0] ptr_hi;
      logic [7:0] ptr_lo;
      logic [7:0] prod_hi;
      logic zf;
      logic [8:0] maddr;
      logic mwe;
      logic [7:0] mwdata;
      logic skip_next;
      logic retired;
   } cmx_state_t;

   cmx_state_t st_reg, st_next;
   cmx_dec_if dec_bus ();
   logic [15:0] prod_s, prod_u;
   logic [7:0] mul_src;

   cmx_decoder u_dec (
      .opcode(instr_word),
      .dec(dec_bus)
   );

   // Signed product of two bytes
   function automatic logic [15:0] mul_signed(input logic [7:0] a, input logic [7:0] b);
      logic signed [15:0] p;
      p = $signed({{8{a[7]}}, a}) * $signed({{8{b[7]}}, b});
      return p;
   endfunction

   // Unsigned product of two bytes
   function automatic logic [15:0] mul_unsigned(input logic [7:0] a, input logic [7:0] b);
      logic [15:0] p;
      p = {8'h00, a} * {8'h00, b};
      return p;
   endfunction

   // Operand for multiplies: memory byte or literal
   always_comb begin
      if (dec_bus.op == cmx_pkg::CMX_MULS_I || dec_bus.op == cmx_pkg::CMX_MULU_I) begin
         mul_src = dec_bus.immediate_byte;
      end else begin
         mul_src = mem_rdata;
      end
   end
   assign prod_s = mul_signed(st_reg.acc, mul_src);
   assign prod_u = mul_unsigned(st_reg.acc, mul_src);

   // Next state from the decoded instruction
   always_comb begin
      st_next = st_reg;
      st_next.mwe = 1'b0;
      st_next.retired = 1'b0;
      st_next.skip_next = 1'b0;
      st_next.maddr = dec_bus.direct_operand;
      if (instr_valid && instr_skip) begin
         // Skipped pointer load extends the skip to the next word
         st_next.skip_next = dec_bus.is_pointer_load;
         st_next.retired = 1'b1;
      end else if (instr_valid) begin
         st_next.retired = 1'b1;
         case (dec_bus.op)
            cmx_pkg::CMX_LDH: st_next.ptr_hi = dec_bus.immediate_byte;
            cmx_pkg::CMX_LDL: st_next.ptr_lo = dec_bus.immediate_byte;
            cmx_pkg::CMX_MOVM: begin
               st_next.mwe = 1'b1;
               st_next.mwdata = st_reg.acc;
            end
            cmx_pkg::CMX_MOVW: begin
               st_next.acc = mem_rdata;
               st_next.zf = (mem_rdata == 8'h00);
            end
            cmx_pkg::CMX_MOVI: st_next.acc = dec_bus.immediate_byte;
            cmx_pkg::CMX_MULS_M, cmx_pkg::CMX_MULS_I: begin
               st_next.acc = prod_s[7:0];
               st_next.prod_hi = prod_s[15:8];
            end
            cmx_pkg::CMX_MULU_M, cmx_pkg::CMX_MULU_I: begin
               st_next.acc = prod_u[7:0];
               st_next.prod_hi = prod_u[15:8];
            end
            cmx_pkg::CMX_NOTM: begin
               st_next.mwe = 1'b1;
               st_next.mwdata = ~mem_rdata;
               st_next.zf = (mem_rdata == 8'hFF);
            end
            default: ; // No-op and foreign opcodes leave state alone
         endcase
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign acc = st_reg.acc;
   assign pointer_high_byte = st_reg.ptr_hi;
   assign pointer_low_byte = st_reg.ptr_lo;
   assign product_high_byte = st_reg.prod_hi;
   assign zero_flag = st_reg.zf;
   assign mem_addr = st_reg.maddr;
   assign mem_we = st_reg.mwe;
   assign mem_wdata = st_reg.mwdata;
   assign skip_next = st_reg.skip_next;
   assign retired = st_reg.retired;

   // Checks
   property p_ldh;
      @(posedge clk) disable iff (sys_rst)
      instr_valid && !instr_skip && instr_word[15:8] == 8'h70 |=>
         pointer_high_byte == $past(instr_word[7:0]) && zero_flag == $past(zero_flag);
   endproperty
   a_ldh: assert property (p_ldh) else $error("pointer high load wrong");
   property p_ldl;
      @(posedge clk) disable iff (sys_rst)
      instr_valid && !instr_skip && instr_word[15:8] == 8'h71 |=>
         pointer_low_byte == $past(instr_word[7:0]) && $stable(pointer_high_byte);
   endproperty
   a_ldl: assert property (p_ldl) else $error("pointer low load wrong");
   property p_xskip;
      @(posedge clk) disable iff (sys_rst)
      instr_valid && instr_skip && instr_word[15:9] == 7'h38 |=> skip_next;
   endproperty
   a_xskip: assert property (p_xskip) else $error("extended skip missing");
   property p_movm;
      @(posedge clk) disable iff (sys_rst)
      instr_valid && !instr_skip && instr_word[15:9] == 7'h01 |=>
         mem_we && mem_wdata == $past(acc) && mem_addr == $past(instr_word[8:0]) && $stable(acc);
   endproperty
   a_movm: assert property (p_movm) else $error("move to memory wrong");
   property p_movw;
      @(posedge clk) disable iff (sys_rst)
      instr_valid && !instr_skip && instr_word[15:9] == 7'h10 |=>
         acc == $past(mem_rdata) && zero_flag == (acc == 8'h00) && !mem_we;
   endproperty
   a_movw: assert property (p_movw) else $error("move to accumulator wrong");
   property p_movi;
      @(posedge clk) disable iff (sys_rst)
      instr_valid && !instr_skip && instr_word[15:8] == 8'h7C |=>
         acc == $past(instr_word[7:0]) && $stable(zero_flag);
   endproperty
   a_movi: assert property (p_movi) else $error("literal move wrong");
   property p_muls;
      @(posedge clk) disable iff (sys_rst)
      instr_valid && !instr_skip && instr_word[15:9] == 7'h2A |=>
         {product_high_byte, acc} == 16'($signed($past(mem_rdata)) * $signed($past(acc)));
   endproperty
   a_muls: assert property (p_muls) else $error("signed multiply wrong");
   property p_mulsi;
      @(posedge clk) disable iff (sys_rst)
      instr_valid && !instr_skip && instr_word[15:8] == 8'h73 |=>
         {product_high_byte, acc} == 16'($signed($past(instr_word[7:0])) * $signed($past(acc)))
         && $stable(zero_flag);
   endproperty
   a_mulsi: assert property (p_mulsi) else $error("signed literal multiply wrong");
   property p_mulu;
      @(posedge clk) disable iff (sys_rst)
      instr_valid && !instr_skip && instr_word[15:9] == 7'h28 |=>
         {product_high_byte, acc} == {8'h00, $past(mem_rdata)} * {8'h00, $past(acc)} && !mem_we;
   endproperty
   a_mulu: assert property (p_mulu) else $error("unsigned multiply wrong");
   property p_nop;
      @(posedge clk) disable iff (sys_rst)
      instr_valid && instr_word == 16'h0000 |=>
         retired && !mem_we && $stable(acc) && $stable(zero_flag) && $stable(product_high_byte);
   endproperty
   a_nop: assert property (p_nop) else $error("no-op changed state");
   property p_not;
      @(posedge clk) disable iff (sys_rst)
      instr_valid && !instr_skip && instr_word[15:9] == 7'h13 |=>
         mem_we && mem_wdata == ~$past(mem_rdata) && zero_flag == (mem_wdata == 8'h00);
   endproperty
   a_not: assert property (p_not) else $error("complement wrong");
   // Unsigned literal multiply splits the product and keeps the zero flag
   property p_mului;
      @(posedge clk) disable iff (sys_rst)
      instr_valid && !instr_skip && instr_word[15:8] == 8'h72 |=>
         {product_high_byte, acc} == {8'h00, $past(instr_word[7:0])} * {8'h00, $past(acc)}
         && $stable(zero_flag);
   endproperty
   a_mului: assert property (p_mului) else $error("unsigned literal multiply wrong");
   // A cancelled word retires but leaves the accumulator, flag, product and pointer bytes alone
   property p_skip_quiet;
      @(posedge clk) disable iff (sys_rst)
      instr_valid && instr_skip |=>
         retired && !mem_we && $stable(acc) && $stable(zero_flag) && $stable(product_high_byte)
         && $stable(pointer_high_byte) && $stable(pointer_low_byte);
   endproperty
   a_skip_quiet: assert property (p_skip_quiet) else $error("skipped word changed state");
   // Extended skip is raised only by a skipped pointer load
   property p_skip_only;
      @(posedge clk) disable iff (sys_rst)
      !(instr_valid && instr_skip && instr_word[15:9] == 7'h38) |=> !skip_next;
   endproperty
   a_skip_only: assert property (p_skip_only) else $error("spurious extended skip");
   // Idle cycles retire nothing and write nothing
   property p_idle;
      @(posedge clk) disable iff (sys_rst)
      !instr_valid |=>
         !retired && !mem_we && !skip_next && $stable(acc) && $stable(zero_flag);
   endproperty
   a_idle: assert property (p_idle) else $error("idle cycle changed state");
   // Pointer high byte moves only on its own load
   property p_ptrh_keep;
      @(posedge clk) disable iff (sys_rst)
      !(instr_valid && !instr_skip && instr_word[15:8] == 8'h70) |=>
         $stable(pointer_high_byte);
   endproperty
   a_ptrh_keep: assert property (p_ptrh_keep) else $error("pointer high byte disturbed");
   // Pointer low byte moves only on its own load
   property p_ptrl_keep;
      @(posedge clk) disable iff (sys_rst)
      !(instr_valid && !instr_skip && instr_word[15:8] == 8'h71) |=>
         $stable(pointer_low_byte);
   endproperty
   a_ptrl_keep: assert property (p_ptrl_keep) else $error("pointer low byte disturbed");
   // Move to memory alters no flag and no product byte
   property p_movm_keep;
      @(posedge clk) disable iff (sys_rst)
      instr_valid && !instr_skip && instr_word[15:9] == 7'h01 |=>
         $stable(zero_flag) && $stable(product_high_byte);
   endproperty
   a_movm_keep: assert property (p_movm_keep) else $error("move to memory touched flags");
   // Signed multiplies never write memory or the zero flag
   property p_muls_keep;
      @(posedge clk) disable iff (sys_rst)
      instr_valid && !instr_skip && (instr_word[15:9] == 7'h2A || instr_word[15:8] == 8'h73) |=>
         $stable(zero_flag) && !mem_we;
   endproperty
   a_muls_keep: assert property (p_muls_keep) else $error("signed multiply side effect");
   // Complement writes back in place and keeps the accumulator
   property p_not_keep;
      @(posedge clk) disable iff (sys_rst)
      instr_valid && !instr_skip && instr_word[15:9] == 7'h13 |=>
         $stable(acc) && $stable(product_high_byte) && mem_addr == $past(instr_word[8:0]);
   endproperty
   a_not_keep: assert property (p_not_keep) else $error("complement side effect");
   // Move to accumulator leaves the product and pointer bytes
   property p_movw_keep;
      @(posedge clk) disable iff (sys_rst)
      instr_valid && !instr_skip && instr_word[15:9] == 7'h10 |=>
         $stable(product_high_byte) && $stable(pointer_high_byte) && $stable(pointer_low_byte);
   endproperty
   a_movw_keep: assert property (p_movw_keep) else $error("move to accumulator side effect");
   // Literal move writes no memory and keeps the product byte
   property p_movi_keep;
      @(posedge clk) disable iff (sys_rst)
      instr_valid && !instr_skip && instr_word[15:8] == 8'h7C |=>
         !mem_we && $stable(product_high_byte);
   endproperty
   a_movi_keep: assert property (p_movi_keep) else $error("literal move side effect");
   // Every accepted word retires one cycle later
   property p_retire;
      @(posedge clk) disable iff (sys_rst)
      instr_valid |=> retired;
   endproperty
   a_retire: assert property (p_retire) else $error("word did not retire");
endmodule
`default_nettype wire

/* logic/cmx_params.svh */
// Opcode patterns and field positions for the move and multiply slice
`ifndef CMX_PARAMS_SVH
`define CMX_PARAMS_SVH
`define CMX_OPC_NOP 16'h0000
`define CMX_OP8_LOAD_HIGH 8'h70
`define CMX_OP8_LOAD_LOW 8'h71
`define CMX_OP8_MULU_IMM 8'h72
`define CMX_OP8_MULS_IMM 8'h73
`define CMX_OP8_MOV_IMM 8'h7C
`define CMX_OP7_MOV_TO_MEM 7'h01
`define CMX_OP7_MOV_TO_ACC 7'h10
`define CMX_OP7_NOT_MEM 7'h13
`define CMX_OP7_MULU_MEM 7'h28
`define CMX_OP7_MULS_MEM 7'h2A
`define CMX_OP8_MSB 15
`define CMX_OP8_LSB 8
`define CMX_OP7_LSB 9
`define CMX_ADDR_MSB 8
`define CMX_IMM_MSB 7
`define CMX_RST_BYTE 8'h00
`endif

/* logic/cmx_pkg.sv */
// Types shared by the move and multiply execute unit
package cmx_pkg;
   typedef enum logic [3:0] {
      CMX_NONE, CMX_LDH, CMX_LDL, CMX_MOVM, CMX_MOVW, CMX_MOVI,
      CMX_MULS_M, CMX_MULS_I, CMX_MULU_M, CMX_MULU_I, CMX_NOTM
   } cmx_op_t;
endpackage

/* logic/cmx_dec_if.sv */
// Decoded instruction carried from the decoder to the execute unit
`timescale 1ns/1ps
`default_nettype none
interface cmx_dec_if;
   cmx_pkg::cmx_op_t op;
   logic [8:0] direct_operand;
   logic [7:0] immediate_byte;
   logic is_pointer_load;
   modport dec (output op, output direct_operand, output immediate_byte, output is_pointer_load);
   modport exe (input op, input direct_operand, input immediate_byte, input is_pointer_load);
endinterface
`default_nettype wire

/* logic/cmx_decoder.sv */
// Combinational opcode decoder for the move and multiply slice
`timescale 1ns/1ps
`default_nettype none
`include "cmx_params.svh"
module cmx_decoder (
   input wire logic [15:0] opcode,
   cmx_dec_if.dec dec
);
   logic [7:0] op8;
   logic [6:0] op7;
   assign op8 = opcode[`CMX_OP8_MSB:`CMX_OP8_LSB];
   assign op7 = opcode[`CMX_OP8_MSB:`CMX_OP7_LSB];
   // Operand fields: low nine bits address, low eight bits literal
   assign dec.direct_operand = opcode[`CMX_ADDR_MSB:0];
   assign dec.immediate_byte = opcode[`CMX_IMM_MSB:0];
   assign dec.is_pointer_load = (op8 == `CMX_OP8_LOAD_HIGH) || (op8 == `CMX_OP8_LOAD_LOW);
   // Pattern match; anything else including the zero opcode is no action
   always_comb begin
      if (op8 == `CMX_OP8_LOAD_HIGH) dec.op = cmx_pkg::CMX_LDH;
      else if (op8 == `CMX_OP8_LOAD_LOW) dec.op = cmx_pkg::CMX_LDL;
      else if (op8 == `CMX_OP8_MOV_IMM) dec.op = cmx_pkg::CMX_MOVI;
      else if (op8 == `CMX_OP8_MULS_IMM) dec.op = cmx_pkg::CMX_MULS_I;
      else if (op8 == `CMX_OP8_MULU_IMM) dec.op = cmx_pkg::CMX_MULU_I;
      else if (op7 == `CMX_OP7_MOV_TO_MEM) dec.op = cmx_pkg::CMX_MOVM;
      else if (op7 == `CMX_OP7_MOV_TO_ACC) dec.op = cmx_pkg::CMX_MOVW;
      else if (op7 == `CMX_OP7_MULS_MEM) dec.op = cmx_pkg::CMX_MULS_M;
      else if (op7 == `CMX_OP7_MULU_MEM) dec.op = cmx_pkg::CMX_MULU_M;
      else if (op7 == `CMX_OP7_NOT_MEM) dec.op = cmx_pkg::CMX_NOTM;
      else dec.op = cmx_pkg::CMX_NONE;
   end
endmodule
`default_nettype wire

/* sim/cmx_mem_model.sv */
// Behavioural data memory on the far side of the execute unit
`timescale 1ns/1ps
`default_nettype none
module cmx_mem_model (
   input wire logic clk,
   input wire logic [8:0] rd_addr,
   input wire logic we,
   input wire logic [8:0] wr_addr,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata
);
   logic [7:0] store [512];
   // Cleared at start so the bench shadow copy agrees
   initial begin
      foreach (store[i]) store[i] = 8'h00;
   end
   // Read follows the fetched word's address in the same cycle
   assign rdata = store[rd_addr];
   // Registered strobe commits the byte at the next edge
   always @(posedge clk) begin
      if (we) store[wr_addr] <= wdata;
   end
endmodule
`default_nettype wire

/* sim/cpu_move_multiply_exec_tb.sv */
// Self-checking bench for the move and multiply execute unit
`timescale 1ns/1ps
`default_nettype none
`include "cmx_params.svh"
module cpu_move_multiply_exec_tb;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic instr_valid = 1'b0;
   logic [15:0] instr_word = 16'h0000;
   logic instr_skip = 1'b0;
   logic [7:0] mem_rdata, mem_wdata, acc, ph, pl, mh;
   logic [8:0] mem_addr;
   logic mem_we, zero_flag, skip_next, retired;
   int fails = 0;
   int check_count = 0;
   logic [7:0] shadow [512];
   logic [7:0] e_acc, e_ph, e_pl, e_mh, e_wd;
   logic e_z, e_we, e_skn;
   logic [7:0] sa [3] = '{8'h07, 8'hF9, 8'hF9};
   logic [7:0] sb [3] = '{8'h06, 8'h06, 8'hFA};
   logic [15:0] base [12] = '{16'h7000, 16'h7100, 16'h7200, 16'h7300, 16'h7C00, 16'h0200,
      16'h2000, 16'h2600, 16'h5000, 16'h5400, 16'h0000, 16'h0006};
   logic [15:0] mask [12] = '{16'h00FF, 16'h00FF, 16'h00FF, 16'h00FF, 16'h00FF, 16'h010F,
      16'h010F, 16'h010F, 16'h010F, 16'h010F, 16'h0000, 16'h0000};
   int k;
   always #50 clk = ~clk;
   cmx_exec dut_u (.clk(clk), .sys_rst(sys_rst), .instr_valid(instr_valid),
      .instr_word(instr_word), .instr_skip(instr_skip), .mem_rdata(mem_rdata),
      .mem_addr(mem_addr), .mem_we(mem_we), .mem_wdata(mem_wdata), .acc(acc),
      .pointer_high_byte(ph), .pointer_low_byte(pl), .product_high_byte(mh),
      .zero_flag(zero_flag), .skip_next(skip_next), .retired(retired));
   cmx_mem_model mem_u (.clk(clk), .rd_addr(instr_word[8:0]), .we(mem_we),
      .wr_addr(mem_addr), .wdata(mem_wdata), .rdata(mem_rdata));
   // Value compare, counted
   task chk(input string name, input logic [8:0] exp, input logic [8:0] got);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   // Expected state after one instruction
   function automatic void predict(input logic [15:0] w, input logic s);
      logic [7:0] m;
      m = shadow[w[8:0]];
      e_we = 1'b0;
      e_skn = s && (w[15:9] == 7'h38);
      if (s) return;
      case (w[15:8])
         `CMX_OP8_LOAD_HIGH: e_ph = w[7:0];
         `CMX_OP8_LOAD_LOW: e_pl = w[7:0];
         `CMX_OP8_MOV_IMM: e_acc = w[7:0];
         `CMX_OP8_MULU_IMM: {e_mh, e_acc} = e_acc * w[7:0];
         `CMX_OP8_MULS_IMM: {e_mh, e_acc} = $signed(e_acc) * $signed(w[7:0]);
         default: case (w[15:9])
            `CMX_OP7_MOV_TO_MEM: {e_we, e_wd} = {1'b1, e_acc};
            `CMX_OP7_MOV_TO_ACC: {e_acc, e_z} = {m, m == 8'h00};
            `CMX_OP7_NOT_MEM: {e_we, e_wd, e_z} = {1'b1, ~m, m == 8'hFF};
            `CMX_OP7_MULU_MEM: {e_mh, e_acc} = e_acc * m;
            `CMX_OP7_MULS_MEM: {e_mh, e_acc} = $signed(e_acc) * $signed(m);
            default: ;
         endcase
      endcase
      if (e_we) shadow[w[8:0]] = e_wd;
   endfunction
   // One instruction, compare just after it retires, then one idle cycle
   task run(input logic [15:0] w, input logic s);
      @(posedge clk);
      instr_valid <= 1'b1;
      instr_word <= w;
      instr_skip <= s;
      predict(w, s);
      @(posedge clk);
      instr_valid <= 1'b0;
      #1;
      chk("acc", e_acc, acc);
      chk("pointer_high", e_ph, ph);
      chk("pointer_low", e_pl, pl);
      chk("product_high", e_mh, mh);
      chk("zero", e_z, zero_flag);
      chk("write", e_we, mem_we);
      if (e_we) chk("addr", w[8:0], mem_addr);
      if (e_we) chk("wdata", e_wd, mem_wdata);
      chk("skip_next", e_skn, skip_next);
      chk("retired", 1'b1, retired);
   endtask
   // Verdict and end of run
   task tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // Watchdog against a hang
   initial begin
      #(100 * 4000);
      fails++;
      tally_and_finish;
   end
   // Directed corners, then random traffic
   initial begin
      void'($urandom(87));
      {e_acc, e_ph, e_pl, e_mh, e_wd, e_z} = '0;
      foreach (shadow[i]) shadow[i] = 8'h00;
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      run(16'h0000, 1'b0);
      for (int i = 0; i < 3; i++) begin
         run({`CMX_OP8_MOV_IMM, sb[i]}, 1'b0);
         run(16'h0299, 1'b0);
         run({`CMX_OP8_MOV_IMM, sa[i]}, 1'b0);
         run(16'h5499, 1'b0);
         run({`CMX_OP8_MOV_IMM, sa[i]}, 1'b0);
         run({`CMX_OP8_MULS_IMM, sb[i]}, 1'b0);
      end
      run(16'h7C00, 1'b0);
      run(16'h03FF, 1'b0);
      run(16'h21FF, 1'b0);
      run(16'h27FF, 1'b0);
      run(16'h0000, 1'b0);
      run(16'h27FF, 1'b0);
      run(16'h7012, 1'b1);
      run(16'h7134, 1'b1);
      run(16'h7C56, 1'b1);
      repeat (300) begin
         k = $urandom_range(0, 11);
         run(base[k] | (16'($urandom) & mask[k]), $urandom_range(0, 7) == 0);
      end
      tally_and_finish;
   end
endmodule
`default_nettype wire
